// *** hw/adc_ctrl_pkg.sv ***
// shared constants for the converter level detect and test pattern block
package adc_ctrl_pkg;

    // ----------------------------------------------------------------
    // serial port framing
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W      = 15;
    localparam int unsigned FRAME_BITS  = 24;
    localparam logic [4:0]  INSTR_LAST  = 5'h0f;
    localparam logic [4:0]  FRAME_LAST  = 5'h17;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [14:0] ADDR_TEST_MODE    = 15'h000d;
    localparam logic [14:0] ADDR_DATA_FORMAT  = 15'h0014;
    localparam logic [14:0] ADDR_USER_FIRST   = 15'h0019;
    localparam logic [14:0] ADDR_USER_LAST    = 15'h0020;
    localparam logic [14:0] ADDR_FD_UPPER_LSB = 15'h0245;
    localparam logic [14:0] ADDR_FD_UPPER_MSB = 15'h0246;
    localparam logic [14:0] ADDR_FD_LOWER_LSB = 15'h0247;
    localparam logic [14:0] ADDR_FD_LOWER_MSB = 15'h0248;
    localparam logic [14:0] ADDR_FD_DWELL_LSB = 15'h0249;
    localparam logic [14:0] ADDR_FD_DWELL_MSB = 15'h024a;
    localparam logic [14:0] ADDR_CAL_THR_LSB  = 15'h024b;
    localparam logic [14:0] ADDR_CAL_THR_MSB  = 15'h024c;
    localparam logic [14:0] ADDR_CAL_GATE     = 15'h024d;
    localparam logic [14:0] ADDR_STATUS       = 15'h024e;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_FD_UPPER  = 16'h0700;
    localparam logic [15:0] RST_FD_LOWER  = 16'h0600;
    localparam logic [15:0] RST_FD_DWELL  = 16'h0010;
    localparam logic [15:0] RST_CAL_THR   = 16'h0000;
    localparam logic        RST_CAL_GATE  = 1'b1;
    localparam logic [15:0] CAL_THR_MAX   = 16'h4000;
    localparam int unsigned MAG_SCALE     = 3;

    // ----------------------------------------------------------------
    // test modes and pattern words
    // ----------------------------------------------------------------
    localparam logic [3:0]  MODE_OFF      = 4'h0;
    localparam logic [3:0]  MODE_MID      = 4'h1;
    localparam logic [3:0]  MODE_POS      = 4'h2;
    localparam logic [3:0]  MODE_NEG      = 4'h3;
    localparam logic [3:0]  MODE_CHECK    = 4'h4;
    localparam logic [3:0]  MODE_PN_LONG  = 4'h5;
    localparam logic [3:0]  MODE_TOGGLE   = 4'h7;
    localparam logic [3:0]  MODE_USER     = 4'h8;
    localparam logic [3:0]  MODE_RAMP     = 4'hf;
    localparam logic [11:0] WORD_MID      = 12'h000;
    localparam logic [11:0] WORD_POS      = 12'h7ff;
    localparam logic [11:0] WORD_NEG      = 12'h800;
    localparam logic [11:0] WORD_CHECK_A  = 12'haaa;
    localparam logic [11:0] WORD_CHECK_B  = 12'h555;
    localparam logic [11:0] WORD_ONES     = 12'hfff;
    localparam logic [11:0] WORD_ZEROS    = 12'h000;
    localparam logic [22:0] PN_SEED       = 23'h7fffff;
    localparam int unsigned PN_TAP_A      = 22;
    localparam int unsigned PN_TAP_B      = 17;
    localparam int unsigned USER_WORDS    = 4;

endpackage

// *** hw/test_pattern_gen.sv ***
// output word selection among converted data and test patterns
`timescale 1ns/1ps
`default_nettype none

module test_pattern_gen
    import adc_ctrl_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  testMode,
    input  wire logic        offsetBinary,
    input  wire logic [11:0] sample,
    input  wire logic [47:0] userWords,
    output var  logic [11:0] dataOut
);

    // ----------------------------------------------------------------
    // pattern state
    // ----------------------------------------------------------------
    logic        phase;
    logic [22:0] pnState;
    logic [11:0] ramp;
    logic [1:0]  userIdx;
    logic [11:0] userWord;
    logic [11:0] rawWord;
    logic        fmtApplies;
    logic [11:0] next_dataOut;

    assign userWord = userWords[12*userIdx +: 12];

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            phase   <= 1'b0;
            pnState <= PN_SEED;
            ramp    <= 12'h000;
            userIdx <= 2'h0;
            dataOut <= 12'h000;
        end
        else
        begin
            phase   <= ~phase;
            pnState <= {pnState[21:0],
                        pnState[PN_TAP_A] ^ pnState[PN_TAP_B]};
            ramp    <= ramp + 12'h001;
            userIdx <= userIdx + 2'h1;
            dataOut <= next_dataOut;
        end
    end

    // ----------------------------------------------------------------
    // selection
    // ----------------------------------------------------------------
    always_comb
    begin
        rawWord    = sample;
        fmtApplies = 1'b1;
        unique case (testMode)
            MODE_MID:     rawWord = WORD_MID;
            MODE_POS:     rawWord = WORD_POS;
            MODE_NEG:     rawWord = WORD_NEG;
            MODE_CHECK:
            begin
                rawWord    = phase ? WORD_CHECK_B : WORD_CHECK_A;
                fmtApplies = 1'b0;
            end
            MODE_PN_LONG: rawWord = pnState[22:11];
            MODE_TOGGLE:
            begin
                rawWord    = phase ? WORD_ZEROS : WORD_ONES;
                fmtApplies = 1'b0;
            end
            MODE_USER:    rawWord = userWord;
            MODE_RAMP:
            begin
                rawWord    = ramp;
                fmtApplies = 1'b0;
            end
            default:      rawWord = sample;
        endcase
    end

    // twos complement words, offset binary flips the sign bit except in checkerboard, toggle and ramp modes
    assign next_dataOut = {rawWord[11] ^ (offsetBinary & fmtApplies),
                           rawWord[10:0]};

endmodule

`default_nettype wire

// *** hw/adc_level_detect.sv ***
// level alarm, calibration gating, serial register port and test patterns
//
// Functional notes
// - register each sample on clock rising edge
// - set alarm when magnitude exceeds upper threshold
// - clear alarm after below-lower dwell exceeded
// - upper, lower, dwell programmed independently
// - accumulate sample magnitudes during calibration
// - update coefficients only if average exceeds threshold
// - calibration gating enabled out of reset
// - sixteen-bit threshold assembled from serial bytes
// - threshold range zero to full scale
// - four-bit test mode, zero passes data
// - constant midscale, positive, negative full words
// - checkerboard alternates every sample
// - long pseudorandom output sequence
// - all ones and zeros alternate
// - user words from its register range
// - ramp increments by one each sample
// - format select only on some patterns
// - alarm on dedicated output pin
`timescale 1ns/1ps
`default_nettype none

module adc_level_detect
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned CAL_LOG2 = 10
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] sampleIn,
    input  wire logic        portSelectN,
    input  wire logic        serialClk,
    input  wire logic        serialDataIn,
    output var  logic        serialDataOut,
    output var  logic        serialDataOe,
    output var  logic        levelAlarmFlag,
    output var  logic        calUpdate,
    output var  logic [11:0] dataOut
);

    localparam int unsigned SUM_W = 12 + MAG_SCALE + CAL_LOG2;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [11:0] magnitude(input logic [11:0] s);
        magnitude = s[11] ? (~s + 12'h001) : s;
    endfunction

    function automatic logic [15:0] clampThr(input logic [15:0] v);
        clampThr = (v > CAL_THR_MAX) ? CAL_THR_MAX : v;
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic selA, selB, clkA, clkB, clkPrev, dinA, dinB;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            selA    <= 1'b1;
            selB    <= 1'b1;
            clkA    <= 1'b0;
            clkB    <= 1'b0;
            clkPrev <= 1'b0;
            dinA    <= 1'b0;
            dinB    <= 1'b0;
        end
        else
        begin
            selA    <= portSelectN;
            selB    <= selA;
            clkA    <= serialClk;
            clkB    <= clkA;
            clkPrev <= clkB;
            dinA    <= serialDataIn;
            dinB    <= dinA;
        end
    end

    logic sclkRise, sclkFall;

    assign sclkRise = clkB & ~clkPrev & ~selB;
    assign sclkFall = ~clkB & clkPrev & ~selB;

    // ----------------------------------------------------------------
    // serial frame: r/w bit, 15-bit address, 8 data bits
    // ----------------------------------------------------------------
    logic [4:0]  bitCnt;
    logic [23:0] shiftReg;
    logic [23:0] next_shiftReg;
    logic [7:0]  readShift;
    logic        readActive;
    logic        instrDone;
    logic        frameDone;
    logic        writeStrobe;
    logic [14:0] writeAddr;
    logic [7:0]  writeData;
    logic [14:0] readAddr;
    logic [7:0]  readData;

    assign next_shiftReg = {shiftReg[22:0], dinB};
    assign instrDone     = sclkRise && (bitCnt == INSTR_LAST);
    assign frameDone     = sclkRise && (bitCnt == FRAME_LAST);
    assign writeStrobe   = frameDone && !next_shiftReg[23];
    assign writeAddr     = next_shiftReg[22:8];
    assign writeData     = next_shiftReg[7:0];
    assign readAddr      = next_shiftReg[14:0];

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || selB)
        begin
            bitCnt        <= 5'h00;
            shiftReg      <= 24'h000000;
            readShift     <= 8'h00;
            readActive    <= 1'b0;
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;
        end
        else
        begin
            if (sclkRise && (bitCnt <= FRAME_LAST))
            begin
                shiftReg <= next_shiftReg;
                bitCnt   <= bitCnt + 5'h01;
            end
            if (instrDone && next_shiftReg[15])
            begin
                readShift  <= readData;
                readActive <= 1'b1;
            end
            else if (sclkFall && readActive)
            begin
                serialDataOut <= readShift[7];
                serialDataOe  <= 1'b1;
                readShift     <= {readShift[6:0], 1'b0};
            end
            if (frameDone)
            begin
                readActive <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [3:0]  testMode;
    logic        offsetBinary;
    logic [7:0]  userBytes [8];
    logic [15:0] fdUpper;
    logic [15:0] fdLower;
    logic [15:0] fdDwell;
    logic [7:0]  calThrShadow;
    logic [15:0] calThr;
    logic        calGate;
    logic        calLastPass;
    logic [47:0] userWords;
    logic        userHit;
    logic [2:0]  userSlot, readSlot;

    assign userHit  = (writeAddr >= ADDR_USER_FIRST)
                   && (writeAddr <= ADDR_USER_LAST);
    assign userSlot = 3'(writeAddr - ADDR_USER_FIRST);
    assign readSlot = 3'(readAddr - ADDR_USER_FIRST);

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            testMode     <= MODE_OFF;
            offsetBinary <= 1'b0;
            fdUpper      <= RST_FD_UPPER;
            fdLower      <= RST_FD_LOWER;
            fdDwell      <= RST_FD_DWELL;
            calThrShadow <= 8'h00;
            calThr       <= RST_CAL_THR;
            calGate      <= RST_CAL_GATE;
            userBytes    <= '{default: 8'h00};
        end
        else if (writeStrobe)
        begin
            if (userHit)
            begin
                userBytes[userSlot] <= writeData;
            end
            unique case (writeAddr)
                ADDR_TEST_MODE:    testMode     <= writeData[3:0];
                ADDR_DATA_FORMAT:  offsetBinary <= writeData[0];
                ADDR_FD_UPPER_LSB: fdUpper[7:0]  <= writeData;
                ADDR_FD_UPPER_MSB: fdUpper[15:8] <= writeData;
                ADDR_FD_LOWER_LSB: fdLower[7:0]  <= writeData;
                ADDR_FD_LOWER_MSB: fdLower[15:8] <= writeData;
                ADDR_FD_DWELL_LSB: fdDwell[7:0]  <= writeData;
                ADDR_FD_DWELL_MSB: fdDwell[15:8] <= writeData;
                ADDR_CAL_THR_LSB:  calThrShadow <= writeData;
                ADDR_CAL_THR_MSB:
                    calThr <= clampThr({writeData, calThrShadow});
                ADDR_CAL_GATE:     calGate      <= writeData[0];
                default:           ;
            endcase
        end
    end

    always_comb
    begin
        readData = 8'h00;
        if ((readAddr >= ADDR_USER_FIRST) && (readAddr <= ADDR_USER_LAST))
        begin
            readData = userBytes[readSlot];
        end
        else
        begin
            unique case (readAddr)
                ADDR_TEST_MODE:    readData = {4'h0, testMode};
                ADDR_DATA_FORMAT:  readData = {7'h00, offsetBinary};
                ADDR_FD_UPPER_LSB: readData = fdUpper[7:0];
                ADDR_FD_UPPER_MSB: readData = fdUpper[15:8];
                ADDR_FD_LOWER_LSB: readData = fdLower[7:0];
                ADDR_FD_LOWER_MSB: readData = fdLower[15:8];
                ADDR_FD_DWELL_LSB: readData = fdDwell[7:0];
                ADDR_FD_DWELL_MSB: readData = fdDwell[15:8];
                ADDR_CAL_THR_LSB:  readData = calThr[7:0];
                ADDR_CAL_THR_MSB:  readData = calThr[15:8];
                ADDR_CAL_GATE:     readData = {7'h00, calGate};
                ADDR_STATUS:
                    readData = {6'h00, calLastPass, levelAlarmFlag};
                default:           readData = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        userWords = 48'h0;
        for (int w = 0; w < USER_WORDS; w++)
        begin
            userWords[12*w +: 12] = {userBytes[2*w+1], userBytes[2*w][7:4]};
        end
    end

    // ----------------------------------------------------------------
    // sample capture
    // ----------------------------------------------------------------
    logic [11:0] sampleReg, magReg;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sampleReg <= 12'h000;
            magReg    <= 12'h000;
        end
        else
        begin
            sampleReg <= sampleIn;
            magReg    <= magnitude(sampleReg);
        end
    end

    // ----------------------------------------------------------------
    // level alarm with hysteresis and dwell
    // ----------------------------------------------------------------
    logic [15:0] dwellCnt;
    logic        aboveUpper;
    logic        belowLower;
    logic        dwellExpired;

    assign aboveUpper   = {4'h0, magReg} > fdUpper;
    assign belowLower   = {4'h0, magReg} < fdLower;
    assign dwellExpired = dwellCnt > fdDwell;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            levelAlarmFlag <= 1'b0;
            dwellCnt       <= 16'h0000;
        end
        else if (aboveUpper)
        begin
            levelAlarmFlag <= 1'b1;
            dwellCnt       <= 16'h0000;
        end
        else if (levelAlarmFlag && belowLower)
        begin
            if (dwellExpired)
            begin
                levelAlarmFlag <= 1'b0;
                dwellCnt       <= 16'h0000;
            end
            else if (dwellCnt != 16'hffff)
            begin
                dwellCnt <= dwellCnt + 16'h0001;
            end
        end
        else
        begin
            dwellCnt <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // calibration amplitude gate
    // ----------------------------------------------------------------
    logic [SUM_W-1:0]    calSum;
    logic [SUM_W-1:0]    calSumNext;
    logic [CAL_LOG2-1:0] calCnt;
    logic [15:0]         calAvg;
    logic                calBlockEnd;

    assign calSumNext  = calSum + SUM_W'({magReg, MAG_SCALE'(0)});
    assign calAvg      = 16'(calSumNext >> CAL_LOG2);
    assign calBlockEnd = &calCnt;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            calSum      <= '0;
            calCnt      <= '0;
            calUpdate   <= 1'b0;
            calLastPass <= 1'b0;
        end
        else
        begin
            calCnt    <= calCnt + 1'b1;
            calUpdate <= 1'b0;
            if (calBlockEnd)
            begin
                calSum      <= '0;
                calLastPass <= calAvg > calThr;
                calUpdate   <= !calGate || (calAvg > calThr);
            end
            else
            begin
                calSum <= calSumNext;
            end
        end
    end

    // ----------------------------------------------------------------
    // output word
    // ----------------------------------------------------------------
    test_pattern_gen patternGen (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .testMode     (testMode),
        .offsetBinary (offsetBinary),
        .sample       (sampleReg),
        .userWords    (userWords),
        .dataOut      (dataOut)
    );

endmodule

`default_nettype wire

// *** bench/adc_level_detect_properties.sv ***
// port checker for the level detect and test pattern block
`timescale 1ns/1ps
`default_nettype none
module adc_level_detect_checker
    import adc_ctrl_pkg::*;
#(
    parameter int unsigned CAL_LOG2 = 10
)
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] sampleIn,
    input  wire logic        portSelectN,
    input  wire logic        serialDataOe,
    input  wire logic        levelAlarmFlag,
    input  wire logic        calUpdate,
    input  wire logic [11:0] dataOut
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [11:0] mag;
    logic        big;
    logic        tiny;
    logic [7:0]  smallRun;
    logic [15:0] calGap;
    logic        calSeen;
    assign mag   = sampleIn[11] ? 12'h000 - sampleIn : sampleIn;
    assign big   = {4'h0, mag} > RST_FD_UPPER;
    assign tiny  = {4'h0, mag} < RST_FD_LOWER;
    always_ff @(posedge core_clk)
    begin
        smallRun <= (!rst_n || !tiny) ? 8'h00
                    : smallRun + {7'h00, smallRun != 8'hff};
        calGap   <= (!rst_n || calUpdate) ? 16'h0000 : calGap + 16'h0001;
        calSeen  <= rst_n && (calSeen || calUpdate);
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_RESET_QUIET: assert property (disable iff (1'b0)
        !rst_n |=> !levelAlarmFlag && !calUpdate && !serialDataOe
        && dataOut == 12'h000) else $error("outputs busy after reset");
    AST_ALARM_SET: assert property (big |-> ##[2:4] levelAlarmFlag)
        else $error("alarm not raised on large sample");
    AST_ALARM_KEEP: assert property (
        levelAlarmFlag && big && $past(big) && $past(big, 2)
        |=> levelAlarmFlag) else $error("alarm dropped while large");
    AST_ALARM_CLEAR: assert property (
        $fell(levelAlarmFlag) |-> $past(smallRun, 3) >= 8'h02
        || !$past(rst_n)) else $error("alarm cleared too early");
    AST_CAL_PULSE: assert property (calUpdate |=> !calUpdate)
        else $error("update pulse longer than one cycle");
    AST_CAL_GAP: assert property (
        calUpdate && calSeen |-> calGap[CAL_LOG2-1:0] == '1)
        else $error("update pulses off the block grid");
    AST_OE_SELECT: assert property (
        $rose(serialDataOe) |-> !portSelectN)
        else $error("read data driven while not selected");
    AST_OE_DROP: assert property (
        portSelectN [*6] |-> !serialDataOe)
        else $error("read data still driven after deselect");
    COV_CLEAR: cover property ($fell(levelAlarmFlag));
    COV_CAL: cover property (calUpdate && calSeen);
    COV_READ: cover property ($rose(serialDataOe));
endmodule
bind adc_level_detect adc_level_detect_checker #(.CAL_LOG2(CAL_LOG2)) i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .sampleIn(sampleIn),
    .portSelectN(portSelectN), .serialDataOe(serialDataOe),
    .levelAlarmFlag(levelAlarmFlag), .calUpdate(calUpdate),
    .dataOut(dataOut));
`default_nettype wire

// *** bench/vga_front_end.sv ***
// variable gain front end model feeding the converter sample input
`timescale 1ns/1ps
`default_nettype none
module vga_front_end
(
    input  wire logic        levelAlarmFlag,
    input  wire logic        agcOn,
    input  wire logic [11:0] amp,
    output var  logic [11:0] sampleOut
);
    logic cut;
    // an open alarm pin reads low through its pull-down
    assign cut = agcOn && (levelAlarmFlag === 1'b1);
    // gain drops by half while the alarm is raised
    assign sampleOut = cut ? {amp[11], amp[11:1]} : amp;
endmodule
`default_nettype wire

// *** bench/test_adc_level_detect.sv ***
// self-checking bench for the level detect and test pattern block
`timescale 1ns/1ps
`default_nettype none
module test_adc_level_detect
    import adc_ctrl_pkg::*;
;
    logic        core_clk;
    logic        rst_n;
    logic        portSelectN;
    logic        serialClk;
    logic        hostBit;
    logic        hostOe;
    logic        sdioWire;
    logic        agcOn;
    logic [11:0] amp;
    logic [11:0] sampleIn;
    logic        serialDataOut;
    logic        serialDataOe;
    logic        levelAlarmFlag;
    logic        calUpdate;
    logic [11:0] dataOut;
    logic [7:0]  q;
    int          errors;
    int          compares;
    assign sdioWire = serialDataOe ? serialDataOut
                      : hostOe ? hostBit : ~serialDataOut;
    vga_front_end i_vga (.levelAlarmFlag(levelAlarmFlag), .agcOn(agcOn),
        .amp(amp), .sampleOut(sampleIn));
    adc_level_detect #(.CAL_LOG2(2)) i_dut (.core_clk(core_clk),
        .rst_n(rst_n), .sampleIn(sampleIn), .portSelectN(portSelectN),
        .serialClk(serialClk), .serialDataIn(sdioWire),
        .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
        .levelAlarmFlag(levelAlarmFlag), .calUpdate(calUpdate),
        .dataOut(dataOut));
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chkWord(input logic [11:0] g, input logic [11:0] e);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: word %h expected %h", $time, g, e);
        end
    endtask
    task automatic chkBit(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            errors++;
            $display("mismatch at %0t: bit %b expected %b", $time, g, e);
        end
    endtask
    task automatic spi(input logic rd, input logic [14:0] a,
                       input logic [7:0] d);
        logic [23:0] f;
        f = {rd, a, d};
        portSelectN = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            hostOe = !(rd && i < 8);
            hostBit = f[i];
            repeat (4) @(negedge core_clk);
            serialClk = 1'b1;
            q = {q[6:0], sdioWire};
            repeat (4) @(negedge core_clk);
            serialClk = 1'b0;
        end
        repeat (4) @(negedge core_clk);
        portSelectN = 1'b1;
        hostOe = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask
    task automatic pair(input logic [3:0] m, output logic [11:0] d0, d1);
        spi(1'b0, ADDR_TEST_MODE, {4'h0, m});
        repeat (3) @(negedge core_clk);
        d0 = dataOut;
        @(negedge core_clk);
        d1 = dataOut;
    endtask
    task automatic waitFlag(input logic v, input int lim, output int n);
        n = 0;
        while (levelAlarmFlag !== v && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= lim)
        begin
            errors++;
            $display("mismatch at %0t: alarm wait ran out", $time);
            finish_test();
        end
    endtask
    task automatic pulses(output int c);
        c = 0;
        repeat (16) @(negedge core_clk) c += (calUpdate === 1'b1);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic testPath();
        for (int i = 0; i < 8; i++)
        begin
            amp = 12'h100 + 12'(i);
            if (i > 1)
                chkWord(dataOut, 12'h0fe + 12'(i));
            @(negedge core_clk);
        end
        chkBit(levelAlarmFlag, 1'b0);
        $display("test path done");
    endtask
    task automatic testModes();
        logic [11:0] d0, d1;
        logic [3:0]  mc [3] = '{4'h1, 4'h2, 4'h3};
        logic [11:0] wc [3] = '{12'h000, 12'h7ff, 12'h800};
        for (int i = 0; i < 3; i++)
        begin
            pair(mc[i], d0, d1);
            chkWord(d1, wc[i]);
        end
        pair(4'h4, d0, d1);
        chkWord(d0 ^ d1, 12'hfff);
        chkBit(d0 === 12'haaa || d0 === 12'h555, 1'b1);
        pair(4'h7, d0, d1);
        chkBit(d0 === ~d1 && (&d0 || ~|d0), 1'b1);
        spi(1'b1, ADDR_TEST_MODE, 8'h00);
        chkWord({8'h00, q[3:0]}, 12'h007);
        pair(4'hf, d0, d1);
        chkWord(d1 - d0, 12'h001);
        amp = 12'h2a5;
        pair(4'h6, d0, d1);
        chkWord(d1, 12'h2a5);
        pair(4'h5, d0, d1);
        chkBit(d0 !== d1 && d1 !== 12'h2a5, 1'b1);
        for (int i = 0; i < 8; i++)
            spi(1'b0, ADDR_USER_FIRST + 15'(i), i[0] ? 8'h3c : 8'h50);
        pair(4'h8, d0, d1);
        chkWord(d1, 12'h3c5);
        spi(1'b0, ADDR_DATA_FORMAT, 8'h01);
        pair(4'h2, d0, d1);
        chkWord(d1, 12'hfff);
        pair(4'h4, d0, d1);
        chkBit(d0 === 12'haaa || d0 === 12'h555, 1'b1);
        spi(1'b0, ADDR_DATA_FORMAT, 8'h00);
        pair(4'h0, d0, d1);
        chkWord(d1, 12'h2a5);
        $display("test modes done");
    endtask
    task automatic testAlarm();
        int n;
        amp = 12'h100;
        spi(1'b0, ADDR_FD_DWELL_LSB, 8'h03);
        spi(1'b0, ADDR_FD_DWELL_MSB, 8'h00);
        amp = 12'h801;
        waitFlag(1'b1, 8, n);
        chkBit(n <= 4, 1'b1);
        amp = 12'h680;
        repeat (30) @(negedge core_clk);
        chkBit(levelAlarmFlag, 1'b1);
        amp = 12'h100;
        waitFlag(1'b0, 30, n);
        chkBit(n >= 5 && n <= 9, 1'b1);
        $display("test alarm done");
    endtask
    task automatic testCal();
        int c;
        amp = 12'h800;
        repeat (8) @(negedge core_clk);
        pulses(c);
        chkWord(12'(c), 12'h004);
        spi(1'b0, ADDR_CAL_THR_LSB, 8'h00);
        spi(1'b0, ADDR_CAL_THR_MSB, 8'h40);
        pulses(c);
        chkWord(12'(c), 12'h000);
        spi(1'b0, ADDR_CAL_THR_LSB, 8'hff);
        pulses(c);
        chkWord(12'(c), 12'h000);
        spi(1'b0, ADDR_CAL_THR_MSB, 8'h3f);
        pulses(c);
        chkWord(12'(c), 12'h004);
        spi(1'b0, ADDR_CAL_THR_MSB, 8'hff);
        pulses(c);
        chkWord(12'(c), 12'h000);
        amp = 12'h000;
        spi(1'b0, ADDR_CAL_GATE, 8'h00);
        pulses(c);
        chkWord(12'(c), 12'h004);
        $display("test calibration done");
    endtask
    initial
    begin
        errors = 0;
        compares = 0;
        rst_n = 1'b0;
        portSelectN = 1'b1;
        serialClk = 1'b0;
        hostBit = 1'b0;
        hostOe = 1'b1;
        agcOn = 1'b0;
        amp = 12'h123;
        q = 8'h00;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        testPath();
        testModes();
        testAlarm();
        testCal();
        finish_test();
    end
endmodule
`default_nettype wire
